// ===== verilog/uedr_pkg.sv
`default_nettype none

package uedr_pkg;

  // ==========================================================================
  // Register map: byte address = 4 * index, index = {dir_in, ep, offset}
  // ==========================================================================
  localparam int unsigned SLOT_NUM     = 16;
  localparam int unsigned SLOT_W       = 4;
  localparam int unsigned EP_W         = 3;
  localparam int unsigned OFF_W        = 3;
  localparam int unsigned IDX_W        = 7;
  localparam int unsigned ADDR_LSB     = 2;
  localparam int unsigned ADDR_MAP_TOP = 9;

  localparam logic [OFF_W-1:0] OFF_CFG   = 3'h0;
  localparam logic [OFF_W-1:0] OFF_BAX   = 3'h1;
  localparam logic [OFF_W-1:0] OFF_CTX   = 3'h2;
  localparam logic [OFF_W-1:0] OFF_EXT_X = 3'h3;
  localparam logic [OFF_W-1:0] OFF_SIZ   = 3'h4;
  localparam logic [OFF_W-1:0] OFF_BAY   = 3'h5;
  localparam logic [OFF_W-1:0] OFF_CTY   = 3'h6;
  localparam logic [OFF_W-1:0] OFF_EXT_Y = 3'h7;
  localparam logic [EP_W-1:0]  EP_CTRL   = 3'h0;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int unsigned CFG_ENABLE   = 7;
  localparam int unsigned CFG_ISO      = 6;
  localparam int unsigned CFG_TOGGLE   = 5;
  localparam int unsigned CFG_DOUBLE_BUFFER_ENABLE     = 4;
  localparam int unsigned CFG_STALL    = 3;
  localparam int unsigned CFG_HI_X_LSB = 3;
  localparam int unsigned CFG_HI_Y_LSB = 0;
  localparam int unsigned CNT_NAK      = 7;
  localparam int unsigned LOW_W        = 7;
  localparam int unsigned EXT_W        = 3;
  localparam int unsigned CNT_W        = 10;
  localparam int unsigned BUF_ADDR_W   = 12;
  localparam int unsigned REG_W        = 8;

  localparam logic [REG_W-1:0] REG_RST         = 8'h00;
  localparam logic [REG_W-1:0] EP0_CFG_WR_MASK = 8'h88;
  localparam logic [REG_W-1:0] EP0_CFG_RD_MASK = 8'ha8;
  localparam logic [REG_W-1:0] FULL_MASK       = 8'hff;
  localparam logic [3:0]       BASE_PAD        = 4'h0;
  localparam logic [LOW_W-1:0] LOW_ONE         = 7'h01;
  localparam logic [CNT_W-1:0] CNT_ONE         = 10'h001;
  localparam logic [EXT_W-1:0] EXT_ZERO        = 3'h0;

  localparam int unsigned HTRANS_ACTIVE = 1;
  localparam logic        HRESP_OKAY    = 1'b0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    UEDR_HS_NONE  = 2'b00,
    UEDR_HS_DATA  = 2'b01,
    UEDR_HS_NAK   = 2'b10,
    UEDR_HS_STALL = 2'b11
  } uedr_hs_t;

  typedef struct packed {
    logic            valid;
    logic [EP_W-1:0] ep;
    logic            dir_in;
    logic            setup;
    logic            data1;
  } uedr_tok_t;

  typedef struct packed {
    logic                  valid;
    uedr_hs_t              hs;
    logic                  iso;
    logic                  buf_y;
    logic [BUF_ADDR_W-1:0] addr;
    logic [CNT_W-1:0]      len;
    logic [CNT_W-1:0]      max;
  } uedr_xfer_t;

endpackage

`default_nettype wire

// ===== verilog/uedr_regs.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module uedr_regs (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire uedr_pkg::uedr_tok_t tok,
  input  wire logic              rx_byte,
  input  wire logic              rx_done,
  input  wire logic              in_done,
  output uedr_pkg::uedr_xfer_t   xfer
);
  import uedr_pkg::*;

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  logic              ap_valid_r;
  logic              ap_write_r;
  logic              ap_map_r;
  logic [IDX_W-1:0]  ap_idx_r;
  logic [31:0]       hrdata_r;
  logic              hreadyout_r;
  logic              hresp_r;
  logic              accept;
  logic [SLOT_W-1:0] ap_slot;
  logic [OFF_W-1:0]  ap_off;
  logic              ap_ok;
  logic              wr_go;
  logic [REG_W-1:0]  rd_val;

  logic [REG_W-1:0]  cfg_w  [SLOT_NUM];
  logic [LOW_W-1:0]  siz_w  [SLOT_NUM];
  logic [REG_W-1:0]  base_w [SLOT_NUM][2];
  logic [REG_W-1:0]  cnt_w  [SLOT_NUM][2];
  logic [EXT_W-1:0]  ext_w  [SLOT_NUM][2];

  // Endpoint 0 keeps only its config and X count; IN offset 7 is absent
  function automatic logic mapped(input logic [SLOT_W-1:0] s, input logic [OFF_W-1:0] o);
    logic ep0;
    ep0 = (s[EP_W-1:0] == EP_CTRL);
    if (ep0) begin
      mapped = (o == OFF_CFG) || (o == OFF_CTX);
    end else begin
      mapped = !(s[SLOT_W-1] && (o == OFF_EXT_Y));
    end
  endfunction

  // hsize is not decoded: every register is one word, low byte used
  assign accept  = hsel && htrans[HTRANS_ACTIVE] && hready;
  assign ap_slot = ap_idx_r[IDX_W-1:OFF_W];
  assign ap_off  = ap_idx_r[OFF_W-1:0];
  assign ap_ok   = ap_map_r && mapped(ap_slot, ap_off);
  assign wr_go   = ap_valid_r && ap_write_r && ap_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_map_r   <= 1'b0;
      ap_idx_r   <= '0;
    end else begin
      ap_valid_r <= accept;
      if (accept) begin
        ap_write_r <= hwrite;
        ap_idx_r   <= haddr[ADDR_LSB +: IDX_W];
        ap_map_r   <= (haddr[31:ADDR_MAP_TOP] == '0);
      end
    end
  end

  // Reads take one wait state so that hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= !(accept && !hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (ap_valid_r && !ap_write_r) begin
      hrdata_r <= {24'h000000, rd_val};
    end
  end

  // Single word transfers only, so every answer is OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= HRESP_OKAY;
    end else begin
      hresp_r <= HRESP_OKAY;
    end
  end

  // Unmapped and reserved places read as zero
  always_comb begin
    rd_val = '0;
    if (ap_ok) begin
      case (ap_off)
        OFF_CFG:   rd_val = cfg_w[ap_slot] & ((ap_slot[EP_W-1:0] == EP_CTRL) ?
                                              EP0_CFG_RD_MASK : FULL_MASK);
        OFF_BAX:   rd_val = base_w[ap_slot][0];
        OFF_CTX:   rd_val = cnt_w[ap_slot][0];
        OFF_EXT_X: rd_val = {5'h00, ext_w[ap_slot][0]};
        OFF_SIZ:   rd_val = {1'b0, siz_w[ap_slot]};
        OFF_BAY:   rd_val = base_w[ap_slot][1];
        OFF_CTY:   rd_val = cnt_w[ap_slot][1];
        OFF_EXT_Y: rd_val = {5'h00, ext_w[ap_slot][1]};
        default:   rd_val = '0;
      endcase
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // ==========================================================================
  // Token decision towards the serial interface engine
  // ==========================================================================
  typedef enum logic [1:0] {
    UEDR_XF_IDLE = 2'b00,
    UEDR_XF_OUT  = 2'b01,
    UEDR_XF_IN   = 2'b10
  } uedr_xf_t;

  logic [SLOT_W-1:0]     t_slot;
  logic [REG_W-1:0]      t_cfg;
  logic [REG_W-1:0]      t_cnt;
  logic                  t_iso;
  logic                  t_buf;
  logic                  t_stall;
  logic                  t_setup0;
  logic [EXT_W-1:0]      t_len_hi;
  logic [EXT_W-1:0]      t_siz_hi;
  uedr_hs_t              t_hs;
  logic                  t_acc;
  uedr_xfer_t            xfer_r;
  uedr_xf_t              state_r;
  uedr_xf_t              state_nxt;
  logic                  active;
  logic                  cur_in;
  logic                  cur_buf_r;
  logic [SLOT_W-1:0]     cur_slot_r;
  logic                  xfer_done;

  always_comb begin
    t_slot   = {tok.dir_in, tok.ep};
    t_cfg    = cfg_w[t_slot];
    t_iso    = t_cfg[CFG_ISO];
    // Isochronous packets carry no toggle; the reported PID picks the buffer
    t_buf    = t_iso ? tok.data1 : (t_cfg[CFG_DOUBLE_BUFFER_ENABLE] & t_cfg[CFG_TOGGLE]);
    t_cnt    = cnt_w[t_slot][t_buf];
    t_setup0 = tok.setup && (tok.ep == EP_CTRL);
    // Bit 3 is a count bit in isochronous mode, so stall only applies outside it
    t_stall  = t_cfg[CFG_STALL] && !t_iso && !t_setup0;
    t_len_hi = t_buf ? t_cfg[CFG_HI_Y_LSB +: EXT_W] : t_cfg[CFG_HI_X_LSB +: EXT_W];
    t_siz_hi = tok.dir_in ? ext_w[t_slot][0] : t_cfg[CFG_HI_Y_LSB +: EXT_W];
    if (!t_cfg[CFG_ENABLE]) begin
      t_hs = UEDR_HS_NONE;
    end else if (t_stall) begin
      t_hs = UEDR_HS_STALL;
    end else if (t_cnt[CNT_NAK]) begin
      t_hs = UEDR_HS_NAK;
    end else begin
      t_hs = UEDR_HS_DATA;
    end
    t_acc = tok.valid && (t_hs == UEDR_HS_DATA);
  end

  assign xfer_done = active && (cur_in ? in_done : rx_done);

  // Fields hold until the next token; only valid is a pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_r <= '0;
    end else begin
      xfer_r.valid <= tok.valid;
      if (tok.valid) begin
        xfer_r.hs    <= t_hs;
        xfer_r.iso   <= t_iso;
        xfer_r.buf_y <= t_buf;
        xfer_r.addr  <= {base_w[t_slot][t_buf], BASE_PAD};
        if (!tok.dir_in) begin
          xfer_r.len <= '0;
        end else if (t_iso) begin
          xfer_r.len <= {t_len_hi, t_cnt[LOW_W-1:0]};
        end else begin
          xfer_r.len <= {EXT_ZERO, t_cnt[LOW_W-1:0]};
        end
        xfer_r.max <= t_iso ? {t_siz_hi, siz_w[t_slot]} : {EXT_ZERO, siz_w[t_slot]};
      end
    end
  end

  assign xfer = xfer_r;

  // A fresh DATA token takes over from a transfer the engine left open
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      UEDR_XF_IDLE: begin
        if (t_acc) begin
          state_nxt = tok.dir_in ? UEDR_XF_IN : UEDR_XF_OUT;
        end
      end
      UEDR_XF_OUT, UEDR_XF_IN: begin
        if (t_acc) begin
          state_nxt = tok.dir_in ? UEDR_XF_IN : UEDR_XF_OUT;
        end else if (xfer_done) begin
          state_nxt = UEDR_XF_IDLE;
        end
      end
      default: begin
        state_nxt = UEDR_XF_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= UEDR_XF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_buf_r  <= 1'b0;
      cur_slot_r <= '0;
    end else if (t_acc) begin
      cur_buf_r  <= t_buf;
      cur_slot_r <= t_slot;
    end
  end

  assign active = (state_r != UEDR_XF_IDLE);
  assign cur_in = (state_r == UEDR_XF_IN);

  // ==========================================================================
  // Descriptor storage, one slot per endpoint and direction
  // ==========================================================================
  for (genvar i = 0; i < SLOT_NUM; i++) begin : g_slot
    localparam logic [SLOT_W-1:0] SLOT   = SLOT_W'(i);
    localparam bit                DIR_IN = SLOT[SLOT_W-1];
    localparam bit                IS_EP0 = (SLOT[EP_W-1:0] == EP_CTRL);
    logic [REG_W-1:0] cfg_r;
    logic [LOW_W-1:0] siz_r;
    logic             wr_here;
    logic             fin_here;

    assign wr_here  = wr_go && (ap_slot == SLOT);
    assign fin_here = xfer_done && (cur_slot_r == SLOT);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_r <= REG_RST;
      end else begin
        if (wr_here && (ap_off == OFF_CFG)) begin
          cfg_r <= IS_EP0 ? ((hwdata[REG_W-1:0] & EP0_CFG_WR_MASK) | (cfg_r & ~EP0_CFG_WR_MASK))
                          : hwdata[REG_W-1:0];
        end
        if (fin_here && !cfg_r[CFG_ISO]) begin
          cfg_r[CFG_TOGGLE] <= ~cfg_r[CFG_TOGGLE];
        end
        // Setup beats a simultaneous software write of the stall flag
        if (IS_EP0 && tok.valid && tok.setup && (tok.ep == EP_CTRL)) begin
          cfg_r[CFG_STALL] <= 1'b0;
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        siz_r <= '0;
      end else if (wr_here && (ap_off == OFF_SIZ)) begin
        siz_r <= hwdata[LOW_W-1:0];
      end
    end

    assign cfg_w[i] = cfg_r;
    assign siz_w[i] = siz_r;

    // X is index 0 and Y index 1 throughout
    for (genvar b = 0; b < 2; b++) begin : g_buf
      localparam logic [OFF_W-1:0] O_BASE = (b == 0) ? OFF_BAX : OFF_BAY;
      localparam logic [OFF_W-1:0] O_CNT  = (b == 0) ? OFF_CTX : OFF_CTY;
      localparam logic [OFF_W-1:0] O_EXT  = (b == 0) ? OFF_EXT_X : OFF_EXT_Y;
      logic [REG_W-1:0] base_r;
      logic [REG_W-1:0] cnt_r;
      logic [EXT_W-1:0] ext_r;
      logic             clr;
      logic             inc;
      logic             fin;
      logic [CNT_W-1:0] tot;

      assign clr = t_acc && !tok.dir_in && (t_slot == SLOT) && (t_buf == 1'(b));
      assign inc = rx_byte && active && !cur_in && (cur_slot_r == SLOT) &&
                   (cur_buf_r == 1'(b));
      assign fin = fin_here && (cur_buf_r == 1'(b));
      // Non-iso counts wrap in 7 bits; software keeps them at or below 64
      assign tot = cfg_r[CFG_ISO] ? ({ext_r, cnt_r[LOW_W-1:0]} + CNT_ONE)
                                  : {EXT_ZERO, cnt_r[LOW_W-1:0] + LOW_ONE};

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          base_r <= REG_RST;
        end else if (wr_here && (ap_off == O_BASE)) begin
          base_r <= hwdata[REG_W-1:0];
        end
      end

      // Hardware NAK set is last so it wins over a same-cycle write
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_r <= REG_RST;
        end else begin
          if (wr_here && (ap_off == O_CNT)) begin
            cnt_r <= hwdata[REG_W-1:0];
          end
          if (clr) begin
            cnt_r[LOW_W-1:0] <= '0;
          end
          if (inc) begin
            cnt_r[LOW_W-1:0] <= tot[LOW_W-1:0];
          end
          if (fin) begin
            cnt_r[CNT_NAK] <= 1'b1;
          end
        end
      end

      // Offset 3 extends the size on IN slots and the X count on OUT slots
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ext_r <= EXT_ZERO;
        end else begin
          if (wr_here && (ap_off == O_EXT)) begin
            ext_r <= hwdata[EXT_W-1:0];
          end
          if (!DIR_IN && cfg_r[CFG_ISO] && clr) begin
            ext_r <= EXT_ZERO;
          end
          if (!DIR_IN && cfg_r[CFG_ISO] && inc) begin
            ext_r <= tot[CNT_W-1:LOW_W];
          end
        end
      end

      assign base_w[i][b] = base_r;
      assign cnt_w[i][b]  = cnt_r;
      assign ext_w[i][b]  = ext_r;
    end
  end

endmodule // uedr_regs

`default_nettype wire

// ===== sim/uedr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

module uedr_regs_properties (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [2:0]           hsize,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire uedr_pkg::uedr_tok_t  tok,
  input wire logic                 rx_byte,
  input wire logic                 rx_done,
  input wire logic                 in_done,
  input wire uedr_pkg::uedr_xfer_t xfer
);
  import uedr_pkg::*;

  // ==========================================================================
  // Bus and link relations
  // ==========================================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_taken;
  logic wr_taken;
  assign rd_taken = hsel & htrans[1] & hready & ~hwrite;
  assign wr_taken = hsel & htrans[1] & hready & hwrite;

  tok_answer_a: assert property (tok.valid |=> xfer.valid)
    else $error("token got no answer");
  answer_single_a: assert property (!tok.valid |=> !xfer.valid)
    else $error("answer without token");
  base_pad_a: assert property (xfer.valid |-> xfer.addr[3:0] == BASE_PAD)
    else $error("buffer address low bits not zero");
  read_wait_a: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (wr_taken |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == HRESP_OKAY && hrdata[31:8] == 24'h0)
    else $error("bad response or upper data");
  short_count_a: assert property (xfer.valid && !xfer.iso && xfer.hs == UEDR_HS_DATA
    |-> xfer.len[9:7] == 3'h0) else $error("non-iso count above 7 bits");
  iso_pick_a: assert property (xfer.valid && xfer.iso && xfer.hs == UEDR_HS_DATA
    |-> xfer.buf_y == $past(tok.data1)) else $error("iso buffer pick wrong");
  setup_stall_a: assert property (tok.valid && tok.setup && tok.ep == EP_CTRL
    |=> xfer.hs != UEDR_HS_STALL) else $error("setup answered with stall");
  iso_nostall_a: assert property (xfer.valid && xfer.iso |-> xfer.hs != UEDR_HS_STALL)
    else $error("stall answered in isochronous mode");

  cover property (xfer.valid && xfer.hs == UEDR_HS_STALL);
  cover property (xfer.valid && xfer.hs == UEDR_HS_NAK);
  cover property (xfer.valid && xfer.iso && xfer.hs == UEDR_HS_DATA);
endmodule // uedr_regs_properties

bind uedr_regs uedr_regs_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .tok, .rx_byte,
  .rx_done, .in_done, .xfer);

`default_nettype wire

// ===== sim/uedr_sie_model.sv
`timescale 1ns/1ps
`default_nettype none

module uedr_sie_model (
  input  wire logic           hclk,
  output uedr_pkg::uedr_tok_t tok,
  output logic                rx_byte,
  output logic                rx_done,
  output logic                in_done
);
  import uedr_pkg::*;

  // ==========================================================================
  // Engine side of the link
  // ==========================================================================
  initial begin
    tok = '0;
    rx_byte = 1'b0;
    rx_done = 1'b0;
    in_done = 1'b0;
  end

  // Fields flip once valid drops, so nothing can lean on stale values
  task automatic send_tok(input logic [EP_W-1:0] ep, input logic d, input logic s,
                          input logic t1);
    @(posedge hclk);
    tok <= '{1'b1, ep, d, s, t1};
    @(posedge hclk);
    tok <= '{1'b0, ~ep, ~d, ~s, ~t1};
  endtask

  task automatic store(input int n);
    repeat (n) begin
      @(posedge hclk);
      rx_byte <= 1'b1;
      @(posedge hclk);
      rx_byte <= 1'b0;
    end
    @(posedge hclk);
    rx_done <= 1'b1;
    @(posedge hclk);
    rx_done <= 1'b0;
  endtask

  task automatic sent();
    @(posedge hclk);
    in_done <= 1'b1;
    @(posedge hclk);
    in_done <= 1'b0;
  endtask
endmodule // uedr_sie_model

`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import uedr_pkg::*;

  typedef struct {
    logic       dir;
    logic [2:0] ep;
    logic [7:0] cfg, x_base_field, cnt, buffer_size_low_bits, ext;
    uedr_hs_t   hs;
    logic [9:0] len, mx;
  } uedr_row_t;

  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        rx_byte, rx_done, in_done;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  uedr_tok_t   tok;
  uedr_xfer_t  xfer;
  uedr_row_t   r;
  int          bad_count = 0;
  int          checked = 0;
  int          cycles = 0;

  // Non-iso rows keep counts within 64 and sizes at 8/16/32/64
  uedr_row_t rows [8] = '{
    '{1'b1, 3'h1, 8'h80, 8'h08, 8'h40, 8'h40, 8'h00, UEDR_HS_DATA, 10'h040, 10'h040},
    '{1'b1, 3'h2, 8'h80, 8'h0c, 8'hc0, 8'h08, 8'h00, UEDR_HS_NAK, 10'h000, 10'h008},
    '{1'b1, 3'h3, 8'h88, 8'h0d, 8'h10, 8'h10, 8'h00, UEDR_HS_STALL, 10'h000, 10'h010},
    '{1'b0, 3'h1, 8'h80, 8'h0e, 8'h85, 8'h20, 8'h00, UEDR_HS_NAK, 10'h000, 10'h020},
    '{1'b1, 3'h6, 8'h00, 8'h0f, 8'h01, 8'h08, 8'h00, UEDR_HS_NONE, 10'h000, 10'h008},
    '{1'b1, 3'h7, 8'hc8, 8'h30, 8'h05, 8'h7f, 8'h05, UEDR_HS_DATA, 10'h085, 10'h2ff},
    '{1'b0, 3'h2, 8'hc3, 8'h40, 8'h00, 8'h10, 8'h02, UEDR_HS_DATA, 10'h000, 10'h190},
    '{1'b0, 3'h3, 8'h80, 8'hff, 8'h00, 8'h20, 8'h00, UEDR_HS_DATA, 10'h000, 10'h020}};

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;

  uedr_regs DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .tok, .rx_byte, .rx_done, .in_done, .xfer);
  uedr_sie_model sie (.hclk, .tok, .rx_byte, .rx_done, .in_done);

  // ==========================================================================
  // Bus master and comparisons
  // ==========================================================================
  function automatic logic [31:0] ra(input logic d, input logic [2:0] ep, off);
    return {23'h0, d, ep, off, 2'b00};
  endfunction

  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk_reg(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    checked++;
    if (rd !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, rd, exp);
    end
  endtask

  // Address, length and size only mean something on a full comparison
  task automatic chk_x(input uedr_hs_t hs, input logic full, input logic y,
                       input logic [11:0] ad, input logic [9:0] len, mx, input logic iso);
    #1;
    checked++;
    if (xfer.valid !== 1'b1 || xfer.hs !== hs || xfer.iso !== iso || (full &&
        (xfer.buf_y !== y || xfer.addr !== ad || xfer.len !== len || xfer.max !== mx))) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, xfer, {hs, iso, y, ad, len, mx});
    end
  endtask

  task automatic wrap_up();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk_reg(ra(1'b1, 3'h1, OFF_CFG), 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, ra(r.dir, r.ep, OFF_CFG), r.cfg);
      bus(1'b1, ra(r.dir, r.ep, OFF_BAX), r.x_base_field);
      bus(1'b1, ra(r.dir, r.ep, OFF_CTX), r.cnt);
      bus(1'b1, ra(r.dir, r.ep, OFF_SIZ), r.buffer_size_low_bits);
      bus(1'b1, ra(r.dir, r.ep, OFF_EXT_X), r.ext);
      sie.send_tok(r.ep, r.dir, 1'b0, 1'b0);
      chk_x(r.hs, r.hs == UEDR_HS_DATA, 1'b0, {r.x_base_field, 4'h0}, r.len, r.mx, r.cfg[6]);
      if (r.hs == UEDR_HS_DATA) begin
        if (r.dir) sie.sent();
        else sie.store(0);
        chk_reg(ra(r.dir, r.ep, OFF_CTX), {24'h0, 1'b1, r.dir ? r.cnt[6:0] : 7'h0});
      end
    end
    // Isochronous IN from Y: DATA1 pick, high count bits from config
    bus(1'b1, ra(1'b1, 3'h7, OFF_CFG), 8'hca);
    bus(1'b1, ra(1'b1, 3'h7, OFF_BAY), 8'h31);
    bus(1'b1, ra(1'b1, 3'h7, OFF_CTY), 8'h03);
    sie.send_tok(3'h7, 1'b1, 1'b0, 1'b1);
    chk_x(UEDR_HS_DATA, 1'b1, 1'b1, 12'h310, 10'h103, 10'h2ff, 1'b1);
    sie.sent();
    chk_reg(ra(1'b1, 3'h7, OFF_CTY), 32'h83);
    // Isochronous OUT running total carries into the extension register
    bus(1'b1, ra(1'b0, 3'h2, OFF_CTX), 8'h00);
    sie.send_tok(3'h2, 1'b0, 1'b0, 1'b0);
    chk_x(UEDR_HS_DATA, 1'b1, 1'b0, 12'h400, 10'h0, 10'h190, 1'b1);
    sie.store(129);
    chk_reg(ra(1'b0, 3'h2, OFF_CTX), 32'h81);
    chk_reg(ra(1'b0, 3'h2, OFF_EXT_X), 32'h01);
    // Double-buffered OUT: running totals and X/Y alternation
    bus(1'b1, ra(1'b0, 3'h4, OFF_CFG), 8'h90);
    bus(1'b1, ra(1'b0, 3'h4, OFF_BAX), 8'h10);
    bus(1'b1, ra(1'b0, 3'h4, OFF_BAY), 8'h20);
    sie.send_tok(3'h4, 1'b0, 1'b0, 1'b0);
    chk_x(UEDR_HS_DATA, 1'b1, 1'b0, 12'h100, 10'h0, 10'h0, 1'b0);
    sie.store(3);
    chk_reg(ra(1'b0, 3'h4, OFF_CTX), 32'h83);
    chk_reg(ra(1'b0, 3'h4, OFF_CFG), 32'hb0);
    sie.send_tok(3'h4, 1'b0, 1'b0, 1'b0);
    chk_x(UEDR_HS_DATA, 1'b1, 1'b1, 12'h200, 10'h0, 10'h0, 1'b0);
    sie.store(1);
    chk_reg(ra(1'b0, 3'h4, OFF_CTY), 32'h81);
    sie.send_tok(3'h4, 1'b0, 1'b0, 1'b0);
    chk_x(UEDR_HS_NAK, 1'b0, 1'b0, 12'h0, 10'h0, 10'h0, 1'b0);
    // Control endpoint: two registers, stall cleared by setup
    bus(1'b1, ra(1'b0, 3'h0, OFF_CFG), 8'hff);
    bus(1'b1, ra(1'b0, 3'h0, OFF_BAX), 8'hff);
    chk_reg(ra(1'b0, 3'h0, OFF_CFG), 32'h88);
    chk_reg(ra(1'b0, 3'h0, OFF_BAX), 32'h0);
    sie.send_tok(3'h0, 1'b0, 1'b0, 1'b0);
    chk_x(UEDR_HS_STALL, 1'b0, 1'b0, 12'h0, 10'h0, 10'h0, 1'b0);
    sie.send_tok(3'h0, 1'b0, 1'b1, 1'b0);
    chk_x(UEDR_HS_DATA, 1'b0, 1'b0, 12'h0, 10'h0, 10'h0, 1'b0);
    chk_reg(ra(1'b0, 3'h0, OFF_CFG), 32'h80);
    // Unmapped and reserved places
    bus(1'b1, 32'h200, 8'hff);
    chk_reg(32'h200, 32'h0);
    chk_reg(ra(1'b1, 3'h1, OFF_EXT_Y), 32'h0);
    // Reset in mid-run returns the descriptors to zero
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_reg(ra(1'b0, 3'h4, OFF_CTX), 32'h0);
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
